// File: rrx_pkg.sv
// shared constants for the return / rotate execution block
package rrx_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 21;
   localparam int INSN_W = 16;
   localparam int BANK_W = 4;
   localparam int FADDR_W = 12;
   // return opcode with option bit masked off
   localparam logic [15:0] RET_MASK = 16'hfffe;
   localparam logic [15:0] RET_CODE = 16'h0012;
   // rotate-left-through-carry opcode upper six bits
   localparam logic [5:0] ROT_CODE = 6'h0d;
   localparam int ROT_OP_MSB = 15;
   localparam int ROT_OP_LSB = 10;
   localparam int BIT_D = 9;
   localparam int BIT_A = 8;
   localparam int BIT_S = 0;
   // literal offset window limit for indexed addressing
   localparam logic [7:0] INDEX_LIMIT = 8'h5f;
   // access bank: offsets 00-5f in bank 0, offsets 60-ff in bank f
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   // status bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 4;
   // first and last q phase of an instruction cycle
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [1:0] Q_FIRST = 2'h0;
endpackage

// File: rrx_rotate.sv
// rotate-left-through-carry datapath with flag results
`timescale 1ns/1ps
module rrx_rotate
#(
   parameter int W = 8
)
(
   // operand
   input wire logic [W-1:0] operand,
   input wire logic carry_in,
   // result
   output logic [W-1:0] result,
   output logic carry_out,
   output logic neg_out,
   output logic zero_out
);
   // msb goes to carry, old carry enters bit 0
   always_comb
   begin
      result = {operand[W-2:0], carry_in};
      carry_out = operand[W-1];
      neg_out = result[W-1];
      zero_out = (result == '0);
   end
endmodule

// File: rrx_exec.sv
// execution of subroutine return and rotate-left-through-carry
// What this block does
// - return pops stack top into program counter
// - option one restores accumulator, flags, bank pointer
// - option zero leaves those three registers alone
// - return never touches pc upper/high latches
// - rotate left; bit7 to carry, carry to bit0
// - d zero writes accumulator, file unchanged
// - d one writes result back to file
// - a zero selects fixed access bank
// - a one uses bank pointer for bank
// - extended set, a zero, f<=95 indexes
`timescale 1ns/1ps
module rrx_exec
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // instruction from decode, held for one clock and captured in idle
   input wire logic insn_valid,
   input wire logic [15:0] insn,
   input wire logic ext_set_en,
   // return stack
   input wire logic [20:0] stack_top_value,
   output logic stack_pop,
   // banked data memory
   output logic [11:0] file_addr,
   output logic file_rd,
   input wire logic [7:0] file_rdata,
   output logic file_wr,
   output logic [7:0] file_wdata,
   // indexed literal offset base pointer
   input wire logic [11:0] index_base,
   // shadow registers
   input wire logic [7:0] shadow_accumulator,
   input wire logic [7:0] shadow_flags,
   input wire logic [3:0] shadow_bank_pointer,
   // architectural state
   output logic [20:0] pc,
   output logic [7:0] accumulator,
   output logic [7:0] flags,
   output logic [3:0] bank_pointer,
   output logic [7:0] pc_upper_latch,
   output logic [7:0] pc_high_latch,
   // fetch control
   output logic flush,
   output logic busy
);
   typedef enum logic [1:0] {S_IDLE, S_RET, S_NOP, S_ROT} state_t;

   state_t state_reg, state_next;
   logic [1:0] q_reg, q_next;
   logic [15:0] op_reg, op_next;
   logic [20:0] pc_reg, pc_next;
   logic [7:0] acc_reg, acc_next;
   logic [7:0] flags_reg, flags_next;
   logic [3:0] bank_reg, bank_next;
   logic [7:0] wdata_reg, wdata_next;
   logic wr_reg, wr_next;
   logic [11:0] addr_comb;
   logic is_ret, is_rot;
   logic [7:0] rot_res;
   logic rot_c, rot_n, rot_z;
   logic [7:0] faddr8;

   assign is_ret = insn_valid && ((insn & rrx_pkg::RET_MASK) == rrx_pkg::RET_CODE);
   assign is_rot = insn_valid
      && (insn[rrx_pkg::ROT_OP_MSB:rrx_pkg::ROT_OP_LSB] == rrx_pkg::ROT_CODE);
   assign faddr8 = op_reg[7:0];

   rrx_rotate #(.W(rrx_pkg::DATA_W)) u_rot
   (
      .operand(file_rdata),
      .carry_in(flags_reg[rrx_pkg::FLAG_C]),
      .result(rot_res),
      .carry_out(rot_c),
      .neg_out(rot_n),
      .zero_out(rot_z)
   );

   // operand address: access bank, indexed window, or banked file
   always_comb
   begin
      if (!op_reg[rrx_pkg::BIT_A])
      begin
         if (ext_set_en && faddr8 <= rrx_pkg::INDEX_LIMIT)
            addr_comb = index_base + {4'h0, faddr8};
         else if (faddr8 < rrx_pkg::ACCESS_SPLIT)
            addr_comb = {rrx_pkg::ACCESS_LO_BANK, faddr8};
         else
            addr_comb = {rrx_pkg::ACCESS_HI_BANK, faddr8};
      end
      else
         addr_comb = {bank_reg, faddr8};
   end

   // sequencer: four q phases per instruction cycle
   always_comb
   begin
      state_next = state_reg;
      q_next = q_reg + 2'h1;
      op_next = op_reg;
      pc_next = pc_reg;
      acc_next = acc_reg;
      flags_next = flags_reg;
      bank_next = bank_reg;
      wdata_next = wdata_reg;
      wr_next = 1'b0;
      case (state_reg)
         S_IDLE:
         begin
            q_next = rrx_pkg::Q_FIRST;
            if (is_ret || is_rot)
            begin
               op_next = insn;
               q_next = 2'h1;
               state_next = is_ret ? S_RET : S_ROT;
            end
         end
         S_RET:
         begin
            if (q_reg == rrx_pkg::Q_LAST)
            begin
               pc_next = stack_top_value;
               if (op_reg[rrx_pkg::BIT_S])
               begin
                  acc_next = shadow_accumulator;
                  flags_next = shadow_flags;
                  bank_next = shadow_bank_pointer;
               end
               state_next = S_NOP;
            end
         end
         S_NOP:
         begin
            if (q_reg == rrx_pkg::Q_LAST)
               state_next = S_IDLE;
         end
         S_ROT:
         begin
            // data is sampled in the last phase; accumulator written at its edge, file one edge later
            if (q_reg == rrx_pkg::Q_LAST)
            begin
               flags_next[rrx_pkg::FLAG_C] = rot_c;
               flags_next[rrx_pkg::FLAG_N] = rot_n;
               flags_next[rrx_pkg::FLAG_Z] = rot_z;
               if (op_reg[rrx_pkg::BIT_D])
               begin
                  wdata_next = rot_res;
                  wr_next = 1'b1;
               end
               else
                  acc_next = rot_res;
               state_next = S_IDLE;
            end
         end
         default:
            state_next = S_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= S_IDLE;
         q_reg <= 2'h0;
         op_reg <= 16'h0000;
         pc_reg <= 21'h000000;
         acc_reg <= 8'h00;
         flags_reg <= 8'h00;
         bank_reg <= 4'h0;
         wdata_reg <= 8'h00;
         wr_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         q_reg <= q_next;
         op_reg <= op_next;
         pc_reg <= pc_next;
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         bank_reg <= bank_next;
         wdata_reg <= wdata_next;
         wr_reg <= wr_next;
      end
   end

   // outputs; latches exist but this block never writes them
   assign pc = pc_reg;
   assign accumulator = acc_reg;
   assign flags = flags_reg;
   assign bank_pointer = bank_reg;
   assign pc_upper_latch = 8'h00;
   assign pc_high_latch = 8'h00;
   assign file_addr = addr_comb;
   assign file_rd = (state_reg == S_ROT);
   assign file_wr = wr_reg;
   assign file_wdata = wdata_reg;
   assign stack_pop = (state_reg == S_RET) && (q_reg == rrx_pkg::Q_LAST);
   assign flush = (state_reg == S_NOP);
   assign busy = (state_reg != S_IDLE);

   sequence s_ret_start;
      state_reg == S_IDLE && is_ret;
   endsequence
   sequence s_ret_pop;
      ##3 stack_pop;
   endsequence

   a_ret_pop_time: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_ret_start |-> s_ret_pop ##1 (pc == $past(stack_top_value)))
      else $error("return did not load pc from stack");
   a_ret_restore: assert property (@(posedge clk_sys) disable iff (!rstn)
      stack_pop && op_reg[0] |=> accumulator == $past(shadow_accumulator)
      && flags == $past(shadow_flags)
      && bank_pointer == $past(shadow_bank_pointer))
      else $error("shadow restore missing");
   a_ret_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
      stack_pop && !op_reg[0] |=> $stable(accumulator) && $stable(flags)
      && $stable(bank_pointer))
      else $error("return without option changed registers");
   a_ret_latches: assert property (@(posedge clk_sys) disable iff (!rstn)
      stack_pop |=> $stable(pc_high_latch) && $stable(pc_upper_latch))
      else $error("return touched pc latches");
   a_ret_two_cycles: assert property (@(posedge clk_sys) disable iff (!rstn)
      stack_pop |=> flush [*4] ##1 !busy)
      else $error("return did not last two cycles");
   a_rot_carry: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_reg == S_ROT && q_reg == 2'h3 |=> flags[0] == $past(file_rdata[7]))
      else $error("carry not taken from bit 7");
   a_rot_to_acc: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_reg == S_ROT && q_reg == 2'h3 && !op_reg[9]
      |=> accumulator == $past(rot_res) && !file_wr)
      else $error("rotate to accumulator wrong");
   a_rot_to_file: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_reg == S_ROT && q_reg == 2'h3 && op_reg[9]
      |=> file_wr && file_wdata == $past(rot_res))
      else $error("rotate write back wrong");
   a_rot_bank: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_reg == S_ROT && op_reg[8] |-> file_addr[11:8] == bank_pointer)
      else $error("banked address wrong");
   a_rot_flags: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_reg == S_ROT && q_reg == 2'h3
      |=> flags[2] == ($past(rot_res) == 8'h00) && flags[4] == $past(rot_res[7]))
      else $error("negative or zero flag wrong");
endmodule

// File: rrx_far_side.sv
// far-side model: return stack and banked data memory
`timescale 1ns/1ps
module rrx_far_side
(
   // clock
   input wire logic clk_sys,
   // return stack
   input wire logic stack_pop,
   output logic [20:0] stack_top_value,
   // data memory
   input wire logic [11:0] file_addr,
   input wire logic file_rd,
   output logic [7:0] file_rdata,
   input wire logic file_wr,
   input wire logic [7:0] file_wdata
);
   logic [7:0] mem [0:4095];
   logic [20:0] stk [0:3];
   logic [1:0] sp = 2'h0;
   logic [11:0] addr_q = 12'h000;
   logic [7:0] last_q = 8'h00;
   int n_wr = 0;
   // unselected memory shows the inverse of the last read, never a stale copy
   assign file_rdata = file_rd ? mem[file_addr] : ~last_q;
   assign stack_top_value = stk[sp];
   // address is latched while reading, since it may drop before the write
   always @(posedge clk_sys)
   begin
      if (file_rd)
      begin
         addr_q <= file_addr;
         last_q <= mem[file_addr];
      end
      if (file_wr)
      begin
         mem[addr_q] <= file_wdata;
         n_wr <= n_wr + 1;
      end
      if (stack_pop)
         sp <= sp - 2'h1;
   end
endmodule

// File: tb.sv
// self-checking testbench for the return / rotate execution block
`timescale 1ns/1ps
module tb;
   logic clk_sys, rstn, insn_valid, ext_set_en, stack_pop, file_rd, file_wr, flush, busy;
   logic [15:0] insn;
   logic [11:0] index_base, file_addr;
   logic [7:0] shadow_accumulator, shadow_flags, file_rdata, file_wdata;
   logic [7:0] accumulator, flags, pc_upper_latch, pc_high_latch, e_acc, e_flags;
   logic [3:0] shadow_bank_pointer, bank_pointer;
   logic [20:0] stack_top_value, pc;
   int miscompares = 0;
   int n_tests = 0;
   int nfl;
   rrx_exec i_rrx_exec (.clk_sys(clk_sys), .rstn(rstn), .insn_valid(insn_valid), .insn(insn),
      .ext_set_en(ext_set_en), .stack_top_value(stack_top_value), .stack_pop(stack_pop),
      .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata), .file_wr(file_wr),
      .file_wdata(file_wdata), .index_base(index_base), .shadow_accumulator(shadow_accumulator),
      .shadow_flags(shadow_flags), .shadow_bank_pointer(shadow_bank_pointer), .pc(pc),
      .accumulator(accumulator), .flags(flags), .bank_pointer(bank_pointer),
      .pc_upper_latch(pc_upper_latch), .pc_high_latch(pc_high_latch), .flush(flush), .busy(busy));
   rrx_far_side i_rrx_far_side (.clk_sys(clk_sys), .stack_pop(stack_pop),
      .stack_top_value(stack_top_value), .file_addr(file_addr), .file_rd(file_rd),
      .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata));
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task finish_test();
      $display("Counts: %0d compares, %0d mismatches", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [20:0] got, input logic [20:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // hold presents a rotate to accumulator while busy, which must be ignored
   task issue(input logic [15:0] w, input logic hold);
      int k;
      k = 0;
      nfl = 0;
      @(negedge clk_sys);
      insn = w;
      insn_valid = 1'b1;
      @(negedge clk_sys);
      insn = 16'h3400;
      insn_valid = hold;
      while (busy !== 1'b0 && k < 20)
      begin
         nfl += int'(flush === 1'b1);
         @(negedge clk_sys);
         k++;
      end
      insn_valid = 1'b0;
      if (k == 20)
      begin
         miscompares++;
         finish_test();
      end
   endtask
   task ret_case(input logic s, input logic hold);
      logic [20:0] top;
      logic [1:0] sp0;
      sp0 = i_rrx_far_side.sp;
      top = i_rrx_far_side.stk[sp0];
      issue({15'h0009, s}, hold);
      if (s)
      begin
         e_acc = shadow_accumulator;
         e_flags = shadow_flags;
      end
      chk(pc, top);
      chk(21'(i_rrx_far_side.sp), 21'(sp0 - 2'h1));
      chk(21'(accumulator), 21'(e_acc));
      chk(21'(flags), 21'(e_flags));
      chk(21'(bank_pointer), 21'(s ? shadow_bank_pointer : 4'h0));
      chk(21'({pc_upper_latch, pc_high_latch}), 21'h0);
      chk(21'(nfl), 21'h4);
      $display("return test done s=%h", s);
   endtask
   task rot_case(input logic d, input logic a, input logic [7:0] f, input logic [11:0] ea,
      input logic [7:0] v);
      logic [7:0] r;
      int w0;
      r = {v[6:0], e_flags[0]};
      i_rrx_far_side.mem[ea] = v;
      w0 = i_rrx_far_side.n_wr;
      issue({6'h0d, d, a, f}, 1'b0);
      // the write strobe is registered, so the file only changes one edge after busy falls
      @(negedge clk_sys);
      e_flags[0] = v[7];
      e_flags[2] = (r == 8'h00);
      e_flags[4] = r[7];
      if (!d)
         e_acc = r;
      chk(21'(flags), 21'(e_flags));
      chk(21'(accumulator), 21'(e_acc));
      chk(21'(i_rrx_far_side.mem[ea]), 21'(d ? r : v));
      chk(21'(i_rrx_far_side.n_wr - w0), 21'(d));
      $display("rotate test done f=%h", f);
   endtask
   initial
   begin
      {rstn, insn_valid, ext_set_en} = 3'h0;
      insn = 16'h0000;
      index_base = 12'h200;
      shadow_accumulator = 8'ha5;
      shadow_flags = 8'h11;
      shadow_bank_pointer = 4'h3;
      e_acc = 8'h00;
      e_flags = 8'h00;
      repeat (10) @(negedge clk_sys);
      rstn = 1'b1;
      i_rrx_far_side.stk[3] = 21'h1abcd;
      i_rrx_far_side.stk[2] = 21'h00246;
      i_rrx_far_side.sp = 2'h3;
      i_rrx_far_side.mem[0] = 8'h81;
      chk(pc, 21'h0);
      ret_case(1'b0, 1'b1);
      ret_case(1'b1, 1'b0);
      rot_case(1'b0, 1'b0, 8'h10, 12'h010, 8'he6);
      rot_case(1'b1, 1'b0, 8'h80, 12'hf80, 8'h40);
      rot_case(1'b1, 1'b1, 8'h80, 12'h380, 8'h80);
      ext_set_en = 1'b1;
      rot_case(1'b1, 1'b0, 8'h5f, 12'h25f, 8'h01);
      rot_case(1'b1, 1'b0, 8'h60, 12'hf60, 8'h02);
      finish_test();
   end
endmodule
